// *** inc/eaw_defs.svh ***
`ifndef EAW_DEFS_SVH
`define EAW_DEFS_SVH
// ========================================
// Register indices
`define EAW_A_CTRLA 4'h0
`define EAW_A_CTRLB 4'h1
`define EAW_A_PERIOD 4'h2
`define EAW_A_ANGLE 4'h3
`define EAW_A_AMP 4'h4
`define EAW_A_CAPT 4'h5
`define EAW_A_SDATA 4'h6
`define EAW_A_SADDR 4'h7
`define EAW_A_TRI 4'h8
`define EAW_A_PHASE_COMPARE_REGS 4'h9
`define EAW_A_CMPV 4'hA
`define EAW_A_CMPW 4'hB
// ========================================
// Field positions
`define EAW_CA_DIR 7
`define EAW_CA_PDIR 6
`define EAW_CA_CKS_HI 5
`define EAW_CA_CKS_LO 4
`define EAW_CA_MOD2 3
`define EAW_CA_AUTO 2
`define EAW_CA_CALC 1
`define EAW_CA_EN 0
`define EAW_CB_WSEL 7
`define EAW_CB_TRG_HI 5
`define EAW_CB_TRG_LO 4
`define EAW_CB_START 3
`define EAW_CB_BUSY 2
`define EAW_CB_ISEL 0
// ========================================
// Reset values, codes and counts
`define EAW_RST_CTRLA 8'h00
`define EAW_RST_CTRLB 8'h30
`define EAW_TRG_STEP 2'h0
`define EAW_TRG_PWM 2'h1
`define EAW_TRG_TRI 2'h2
`define EAW_ANG_MAX 9'h17F
`define EAW_ANG_HALF 9'h0C0
`define EAW_OFS_120 9'h080
`define EAW_OFS_240 9'h100
`define EAW_TURN 10'h180
`define EAW_PER_MIN 12'h010
`define EAW_CALC_2P 6'h20
`define EAW_CALC_3P 6'h23
`endif

// *** inc/eaw_pkg.sv ***
package eaw_pkg;
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } eaw_bus_req_t;
    typedef struct packed {
        logic [11:0] u;
        logic [11:0] v;
        logic [11:0] w;
    } eaw_duty_t;
    typedef enum logic [1:0] {
        EAW_IDLE = 2'b01,
        EAW_CALC = 2'b10
    } eaw_state_t;
endpackage

// *** verilog/eaw_engine.sv ***
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "eaw_defs.svh"
module eaw_engine
    import eaw_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire eaw_bus_req_t bus_req,
    output logic [15:0] rd_data,
    input wire logic [11:0] pwm_period_value,
    input wire logic pwm_period_evt,
    input wire logic pos_detect_evt,
    output eaw_duty_t duty,
    output logic [8:0] angle_now,
    output logic angle_step_irq,
    output logic calc_busy_flag
);

// ========================================
// Helpers
function automatic logic [8:0] eaw_wrap(input logic [8:0] a, input logic [8:0] off);
    logic [9:0] s;
    s = {1'b0, a} + {1'b0, off};
    if (s >= `EAW_TURN) begin
        s = s - `EAW_TURN;
    end
    return s[8:0];
endfunction

function automatic logic [11:0] eaw_phase(input logic [8:0] ang, input logic [7:0] sv,
    input logic [11:0] voltage_amplitude, input logic [11:0] per, input logic two);
    logic [19:0] prod;
    logic [11:0] p;
    logic [12:0] hp;
    logic [12:0] half;
    logic [12:0] sum;
    logic [11:0] res;
    prod = {12'h000, sv} * {8'h00, voltage_amplitude};
    p = prod[19:8];
    hp = {2'b00, p[11:1]};
    half = {2'b00, per[11:1]};
    if (two) begin
        res = (p > per) ? per : p;
    end else if (ang < `EAW_ANG_HALF) begin
        sum = half + hp;
        res = (sum > {1'b0, per}) ? per : sum[11:0];
    end else begin
        sum = (hp > half) ? 13'h0000 : half - hp;
        res = sum[11:0];
    end
    return res;
endfunction

// ========================================
// Registers
logic [7:0] ctla_ff;
logic [7:0] ctlb_ff;
logic [15:0] per_ff;
logic [8:0] ang_ff;
logic [11:0] amp_ff;
logic [8:0] cap_ff;
logic [8:0] saddr_ff;
logic [7:0] tri_ff [0:2];
logic [1:0] tri_idx_ff;
logic [7:0] sine_ram [0:383];
eaw_duty_t duty_ff;
eaw_duty_t res_ff;
logic [15:0] rdata_ff;
logic [2:0] presc_ff;
logic [12:0] tcnt_ff;
logic [3:0] acc_ff;
eaw_state_t state_ff;
logic [5:0] cyc_ff;
logic [8:0] pa_ff [0:2];
logic [7:0] sv_ff [0:2];
logic irq_ff;
logic done;

wire logic is_wr = bus_req.wr;
wire logic [3:0] addr = bus_req.addr;
wire logic [15:0] wd = bus_req.wdata;
wire logic tmr_en = ctla_ff[`EAW_CA_EN];
wire logic calc_en = ctla_ff[`EAW_CA_CALC];
wire logic auto_on = calc_en & ctla_ff[`EAW_CA_AUTO];
wire logic two_ph = ctla_ff[`EAW_CA_MOD2];
wire logic [1:0] cks = ctla_ff[`EAW_CA_CKS_HI:`EAW_CA_CKS_LO];
wire logic [1:0] trg = ctlb_ff[`EAW_CB_TRG_HI:`EAW_CB_TRG_LO];
wire logic wr_ca = is_wr && addr == `EAW_A_CTRLA;
wire logic wr_ang = is_wr && addr == `EAW_A_ANGLE && wd[8:0] <= `EAW_ANG_MAX;
wire logic wr_tri = is_wr && addr == `EAW_A_TRI;
wire logic sw_start = is_wr && addr == `EAW_A_CTRLB && wd[`EAW_CB_START];
wire logic en_clr = wr_ca && !wd[`EAW_CA_EN];

// ========================================
// Control registers
always_ff @(posedge clk_sys) begin
    if (rst) begin
        ctla_ff <= `EAW_RST_CTRLA;
        ctlb_ff <= `EAW_RST_CTRLB;
        per_ff <= 16'h0000;
        amp_ff <= 12'h000;
        saddr_ff <= 9'h000;
    end else if (is_wr) begin
        case (addr)
            `EAW_A_CTRLA: ctla_ff <= wd[7:0];
            `EAW_A_CTRLB: ctlb_ff <= {wd[7], 1'b0, wd[5:4], 3'b000, wd[0]};
            `EAW_A_PERIOD: per_ff <= wd;
            `EAW_A_AMP: amp_ff <= wd[11:0];
            `EAW_A_SADDR: saddr_ff <= wd[8:0];
            default: ;
        endcase
    end
end

// ========================================
// Tick prescaler and period counter
logic tick;
always_comb begin
    case (cks)
        2'h0: tick = 1'b1;
        2'h1: tick = presc_ff[0];
        2'h2: tick = &presc_ff[1:0];
        default: tick = &presc_ff;
    endcase
end

always_ff @(posedge clk_sys) begin
    if (rst) begin
        presc_ff <= 3'h0;
    end else begin
        presc_ff <= presc_ff + 3'h1;
    end
end

wire logic [11:0] per_m = (per_ff[11:0] < `EAW_PER_MIN) ? `EAW_PER_MIN : per_ff[11:0];
wire logic [4:0] acc_sum = {1'b0, acc_ff} + {1'b0, per_ff[15:12]};
wire logic [12:0] per_eff = {1'b0, per_m} + {12'h000, acc_sum[4]};
wire logic step = tmr_en && tick && (tcnt_ff >= per_eff - 13'h0001);

always_ff @(posedge clk_sys) begin
    if (rst) begin
        tcnt_ff <= 13'h0000;
        acc_ff <= 4'h0;
    end else if (wr_ang || !tmr_en || step) begin
        tcnt_ff <= 13'h0000;
        if (step) begin
            acc_ff <= acc_sum[3:0];
        end
    end else if (tick) begin
        tcnt_ff <= tcnt_ff + 13'h0001;
    end
end

// ========================================
// Angle counter and capture
always_ff @(posedge clk_sys) begin
    if (rst) begin
        ang_ff <= 9'h000;
    end else if (wr_ang) begin
        ang_ff <= wd[8:0];
    end else if (en_clr) begin
        ang_ff <= 9'h000;
    end else if (step) begin
        if (!ctla_ff[`EAW_CA_DIR]) begin
            ang_ff <= (ang_ff >= `EAW_ANG_MAX) ? 9'h000 : ang_ff + 9'h001;
        end else begin
            ang_ff <= (ang_ff == 9'h000) ? `EAW_ANG_MAX : ang_ff - 9'h001;
        end
    end
end

always_ff @(posedge clk_sys) begin
    if (rst) begin
        cap_ff <= 9'h000;
    end else if (pos_detect_evt) begin
        cap_ff <= ang_ff;
    end
end

// ========================================
// Sine table and three-phase data input
always_ff @(posedge clk_sys) begin
    if (is_wr && addr == `EAW_A_SDATA && ang_ff <= `EAW_ANG_MAX) begin
        sine_ram[ang_ff] <= wd[7:0];
    end
end

always_ff @(posedge clk_sys) begin
    if (rst) begin
        tri_idx_ff <= 2'h0;
        tri_ff[0] <= 8'h00;
        tri_ff[1] <= 8'h00;
        tri_ff[2] <= 8'h00;
    end else if (wr_tri) begin
        tri_ff[tri_idx_ff] <= wd[7:0];
        tri_idx_ff <= (tri_idx_ff == 2'h2) ? 2'h0 : tri_idx_ff + 2'h1;
    end
end

// ========================================
// Calculation sequencer
logic evt;
always_comb begin
    case (trg)
        `EAW_TRG_STEP: evt = step || wr_ang;
        `EAW_TRG_PWM: evt = pwm_period_evt;
        `EAW_TRG_TRI: evt = wr_tri && tri_idx_ff == 2'h2;
        default: evt = 1'b0;
    endcase
end

// Event starts while busy are dropped, so old results stand
wire logic start = sw_start || (calc_en && evt && state_ff == EAW_IDLE);
assign done = state_ff == EAW_CALC && cyc_ff == 6'h00;

always_ff @(posedge clk_sys) begin
    if (rst) begin
        state_ff <= EAW_IDLE;
        cyc_ff <= 6'h00;
    end else if (start) begin
        state_ff <= EAW_CALC;
        cyc_ff <= (two_ph ? `EAW_CALC_2P : `EAW_CALC_3P) - 6'h01;
    end else begin
        case (state_ff)
            EAW_IDLE: cyc_ff <= 6'h00;
            EAW_CALC: begin
                if (done) begin
                    state_ff <= EAW_IDLE;
                end else begin
                    cyc_ff <= cyc_ff - 6'h01;
                end
            end
            default: state_ff <= EAW_IDLE;
        endcase
    end
end

// Angles and samples frozen at start; amplitude, period and mode read live
wire logic [8:0] ofs_v = ctla_ff[`EAW_CA_PDIR] ? `EAW_OFS_240 : `EAW_OFS_120;
wire logic [8:0] ofs_w = ctla_ff[`EAW_CA_PDIR] ? `EAW_OFS_120 : `EAW_OFS_240;
logic [8:0] nang [0:2];
always_comb begin
    nang[0] = ang_ff;
    nang[1] = eaw_wrap(ang_ff, ofs_v);
    nang[2] = eaw_wrap(ang_ff, ofs_w);
end

// Third data write feeds its own byte into the calculation it starts
logic [7:0] tri_in [0:2];
always_comb begin
    tri_in[0] = tri_ff[0];
    tri_in[1] = tri_ff[1];
    tri_in[2] = (wr_tri && tri_idx_ff == 2'h2) ? wd[7:0] : tri_ff[2];
end

always_ff @(posedge clk_sys) begin
    if (rst) begin
        for (int i = 0; i < 3; i++) begin
            pa_ff[i] <= 9'h000;
            sv_ff[i] <= 8'h00;
        end
    end else if (start) begin
        for (int i = 0; i < 3; i++) begin
            pa_ff[i] <= nang[i];
            sv_ff[i] <= ctlb_ff[`EAW_CB_WSEL] ? tri_in[i] : sine_ram[nang[i]];
        end
    end
end

eaw_duty_t calc;
always_comb begin
    calc.u = eaw_phase(pa_ff[0], sv_ff[0], amp_ff, pwm_period_value, two_ph);
    calc.v = eaw_phase(pa_ff[1], sv_ff[1], amp_ff, pwm_period_value, two_ph);
    calc.w = eaw_phase(pa_ff[2], sv_ff[2], amp_ff, pwm_period_value, two_ph);
end

// ========================================
// Results and compare registers
always_ff @(posedge clk_sys) begin
    if (rst) begin
        res_ff <= '0;
    end else if (done) begin
        res_ff <= calc;
    end
end

always_ff @(posedge clk_sys) begin
    if (rst) begin
        duty_ff <= '0;
    end else if (done && auto_on) begin
        duty_ff <= calc;
    end else if (is_wr && !auto_on) begin
        case (addr)
            `EAW_A_PHASE_COMPARE_REGS: duty_ff.u <= wd[11:0];
            `EAW_A_CMPV: duty_ff.v <= wd[11:0];
            `EAW_A_CMPW: duty_ff.w <= wd[11:0];
            default: ;
        endcase
    end
end

always_ff @(posedge clk_sys) begin
    if (rst) begin
        irq_ff <= 1'b0;
    end else begin
        irq_ff <= ctlb_ff[`EAW_CB_ISEL] ? done : step;
    end
end

// ========================================
// Read port
eaw_duty_t cmp_view;
assign cmp_view = ctla_ff[`EAW_CA_AUTO] ? duty_ff : res_ff;
logic [15:0] rmux;
always_comb begin
    case (addr)
        `EAW_A_CTRLA: rmux = {8'h00, ctla_ff};
        `EAW_A_CTRLB: rmux = {8'h00, ctlb_ff | {5'h00, state_ff == EAW_CALC, 2'h0}};
        `EAW_A_PERIOD: rmux = per_ff;
        `EAW_A_ANGLE: rmux = {7'h00, ang_ff};
        `EAW_A_AMP: rmux = {4'h0, amp_ff};
        `EAW_A_CAPT: rmux = {7'h00, cap_ff};
        `EAW_A_SDATA: rmux = (saddr_ff <= `EAW_ANG_MAX) ? {8'h00, sine_ram[saddr_ff]} : 16'h0000;
        `EAW_A_SADDR: rmux = {7'h00, saddr_ff};
        `EAW_A_PHASE_COMPARE_REGS: rmux = {4'h0, cmp_view.u};
        `EAW_A_CMPV: rmux = {4'h0, cmp_view.v};
        `EAW_A_CMPW: rmux = {4'h0, cmp_view.w};
        default: rmux = 16'h0000;
    endcase
end

always_ff @(posedge clk_sys) begin
    if (rst) begin
        rdata_ff <= 16'h0000;
    end else begin
        rdata_ff <= bus_req.rd ? rmux : 16'h0000;
    end
end

assign rd_data = rdata_ff;
assign duty = duty_ff;
assign angle_now = ang_ff;
assign angle_step_irq = irq_ff;
assign calc_busy_flag = state_ff == EAW_CALC;

// ========================================
// Checks
default clocking cb @(posedge clk_sys); endclocking
default disable iff (rst);

angle_range_a: assert property (ang_ff <= `EAW_ANG_MAX)
    else $error("angle out of range");
wrap_up_a: assert property (step && !wr_ang && !en_clr && !ctla_ff[`EAW_CA_DIR]
    && ang_ff == `EAW_ANG_MAX |=> ang_ff == 9'h000)
    else $error("angle did not wrap");
per_floor_a: assert property (per_eff >= 13'h0010)
    else $error("period below floor");
busy_two_a: assert property (start && two_ph |=> calc_busy_flag && cyc_ff == 6'h1F)
    else $error("two-phase length wrong");
busy_three_a: assert property (start && !two_ph ##1 !start[*8] |-> calc_busy_flag
    && cyc_ff == 6'h1B)
    else $error("three-phase length wrong");
auto_load_a: assert property (done && auto_on |=> duty_ff == $past(calc))
    else $error("auto transfer missed");
cmp_lock_a: assert property (is_wr && addr == `EAW_A_PHASE_COMPARE_REGS && auto_on && !done
    |=> $stable(duty_ff.u))
    else $error("locked compare written");
angle_reject_a: assert property (is_wr && addr == `EAW_A_ANGLE && wd[8:0] > `EAW_ANG_MAX
    && !step && !en_clr |=> $stable(ang_ff))
    else $error("bad angle accepted");
disable_clr_a: assert property (en_clr && !wr_ang |=> ang_ff == 9'h000)
    else $error("angle not cleared");
capture_a: assert property (pos_detect_evt |=> cap_ff == $past(ang_ff))
    else $error("capture wrong");
irq_step_a: assert property (step && !ctlb_ff[`EAW_CB_ISEL] |=> angle_step_irq)
    else $error("step interrupt missing");

wrap_c: cover property (step && ang_ff == `EAW_ANG_MAX);
restart_c: cover property (sw_start && calc_busy_flag);
three_done_c: cover property (done && !two_ph && auto_on);
corr_step_c: cover property (step && acc_sum[4]);
endmodule

// *** test/eaw_pwm_model.sv ***
`timescale 1ns/1ps
module eaw_pwm_model
    import eaw_pkg::*;
#(
    parameter logic [11:0] PERIOD_VAL = 12'h0C8,
    parameter int EVT_SPAN = 100
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire eaw_duty_t duty,
    output logic [11:0] pwm_period_value,
    output logic pwm_period_evt
);
    // ========================================
    // Period counter and compare latch
    int cnt_ff;
    eaw_duty_t cmp_ff;
    assign pwm_period_value = PERIOD_VAL;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_ff <= 0;
            pwm_period_evt <= 1'b0;
        end else begin
            cnt_ff <= (cnt_ff == EVT_SPAN - 1) ? 0 : cnt_ff + 1;
            pwm_period_evt <= (cnt_ff == EVT_SPAN - 1);
        end
    end
    // Duties load only at a period boundary
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cmp_ff <= '0;
        end else if (pwm_period_evt) begin
            cmp_ff <= duty;
        end
    end
endmodule

// *** test/electrical_angle_sine_waveform_engine_tb_top.sv ***
`timescale 1ns/1ps
`include "eaw_defs.svh"
module electrical_angle_sine_waveform_engine_tb_top
    import eaw_pkg::*;
;
    localparam int PER = 200;
    logic clk_sys;
    logic rst;
    eaw_bus_req_t bus_req;
    logic [15:0] rd_data;
    logic [11:0] pwm_period_value;
    logic pwm_period_evt;
    logic pos_detect_evt;
    eaw_duty_t duty;
    logic [8:0] angle_now;
    logic angle_step_irq;
    logic calc_busy_flag;
    int num_errors = 0;
    int n_compared = 0;
    typedef struct {
        logic [15:0] ctrla;
        logic [15:0] angle;
        logic [15:0] voltage_amplitude;
    } eaw_row_t;
    eaw_row_t rows [7] = '{'{16'h000E, 16'h0000, 16'h0100}, '{16'h000E, 16'h017F, 16'h0300},
        '{16'h0006, 16'h0000, 16'h0100}, '{16'h0046, 16'h00BF, 16'h0100},
        '{16'h0006, 16'h00C0, 16'h0FFF}, '{16'h000A, 16'h0050, 16'h0100},
        '{16'h004A, 16'h0100, 16'h0200}};

    eaw_engine uut (.clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
        .pwm_period_value(pwm_period_value), .pwm_period_evt(pwm_period_evt),
        .pos_detect_evt(pos_detect_evt), .duty(duty), .angle_now(angle_now),
        .angle_step_irq(angle_step_irq), .calc_busy_flag(calc_busy_flag));
    eaw_pwm_model #(.PERIOD_VAL(12'(PER)), .EVT_SPAN(100)) u_pwm (.clk_sys(clk_sys),
        .rst(rst), .duty(duty), .pwm_period_value(pwm_period_value),
        .pwm_period_evt(pwm_period_evt));

    initial clk_sys = 1'b0;
    always #50 clk_sys = ~clk_sys;

    // ========================================
    // Bus, compare and wait tasks
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkn(input string nm, input int e, input int g);
        n_compared++;
        if (g != e) begin
            num_errors++;
            $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        @(negedge clk_sys);
        chk(nm, e, rd_data);
    endtask
    task automatic busy_len(output int n);
        n = 0;
        @(negedge clk_sys);
        while (calc_busy_flag === 1'b1 && n < 100) begin
            n++;
            @(negedge clk_sys);
        end
    endtask
    task automatic wirq(output int c);
        c = 0;
        do begin
            @(negedge clk_sys);
            c++;
        end while (angle_step_irq !== 1'b1 && c < 3000);
        if (angle_step_irq !== 1'b1) begin
            num_errors++;
            $display("MISMATCH irq_wait expected 1 seen %b", angle_step_irq);
        end
    endtask
    function automatic int sbyte(input int a);
        return (a * 37 + 11) % 256;
    endfunction
    function automatic logic [11:0] edut(input int a, input bit three, input int voltage_amplitude);
        int p;
        p = (sbyte(a) * voltage_amplitude) >> 8;
        if (!three) return 12'((p > PER) ? PER : p);
        if (a < 192) return 12'((PER / 2 + p / 2 > PER) ? PER : PER / 2 + p / 2);
        return 12'((p / 2 > PER / 2) ? 0 : PER / 2 - p / 2);
    endfunction

    initial begin
        repeat (60000) @(posedge clk_sys);
        num_errors++;
        conclude();
    end

    // ========================================
    // Main sequence
    initial begin
        int n;
        int c;
        int s;
        int va;
        int wa;
        bit three;
        logic [11:0] eu;
        logic [11:0] ev;
        logic [11:0] ew;
        logic [11:0] pu;
        rst = 1'b1;
        bus_req = '0;
        pos_detect_evt = 1'b0;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        rdc("ctrla", `EAW_A_CTRLA, 16'h0000);
        rdc("ctrlb", `EAW_A_CTRLB, 16'h0030);
        wr(`EAW_A_ANGLE, 16'h017F);
        rdc("angle", `EAW_A_ANGLE, 16'h017F);
        wr(`EAW_A_ANGLE, 16'h0180);
        rdc("angle_big", `EAW_A_ANGLE, 16'h017F);
        wr(4'hC, 16'hFFFF);
        rdc("unmapped", 4'hC, 16'h0000);
        for (int a = 0; a < 384; a++) begin
            wr(`EAW_A_ANGLE, 16'(a));
            wr(`EAW_A_SDATA, 16'(sbyte(a)));
        end
        wr(`EAW_A_SADDR, 16'h017F);
        rdc("table", `EAW_A_SDATA, 16'(sbyte(383)));
        foreach (rows[i]) begin
            three = !rows[i].ctrla[3];
            va = (rows[i].angle + (rows[i].ctrla[6] ? 256 : 128)) % 384;
            wa = (rows[i].angle + (rows[i].ctrla[6] ? 128 : 256)) % 384;
            eu = edut(rows[i].angle, three, rows[i].voltage_amplitude);
            ev = edut(va, three, rows[i].voltage_amplitude);
            ew = edut(wa, three, rows[i].voltage_amplitude);
            wr(`EAW_A_CTRLA, rows[i].ctrla);
            wr(`EAW_A_ANGLE, rows[i].angle);
            wr(`EAW_A_AMP, rows[i].voltage_amplitude);
            wr(`EAW_A_CTRLB, 16'h0038);
            busy_len(n);
            chkn("calc_len", three ? 35 : 32, n);
            rdc("cmp_u", `EAW_A_PHASE_COMPARE_REGS, {4'h0, eu});
            rdc("cmp_v", `EAW_A_CMPV, {4'h0, ev});
            rdc("cmp_w", `EAW_A_CMPW, {4'h0, ew});
            if (rows[i].ctrla[2]) begin
                pu = eu;
                chk("duty_w", {4'h0, ew}, {4'h0, duty.w});
            end
            wr(`EAW_A_PHASE_COMPARE_REGS, 16'h0ABC);
            @(negedge clk_sys);
            if (!rows[i].ctrla[2]) pu = 12'hABC;
            chk("duty_u", {4'h0, pu}, {4'h0, duty.u});
        end
        wr(`EAW_A_CTRLB, 16'h0038);
        repeat (10) @(posedge clk_sys);
        wr(`EAW_A_CTRLB, 16'h0039);
        busy_len(n);
        chkn("restart_len", 32, n);
        chk("irq_calc", 16'h0001, {15'h0000, angle_step_irq});
        @(negedge clk_sys);
        chk("irq_calc_end", 16'h0000, {15'h0000, angle_step_irq});
        wr(`EAW_A_CTRLA, 16'h000E);
        wr(`EAW_A_AMP, 16'h0100);
        for (int k = 0; k < 4; k++) begin
            wr(`EAW_A_CTRLB, 16'((k == 2 ? 8'h80 : 8'h00) | (k << 4)));
            c = 0;
            do begin
                @(negedge clk_sys);
                c++;
            end while (pwm_period_evt !== 1'b1 && c < 300);
            chk("pwm_seen", 16'h0001, {15'h0000, pwm_period_evt});
            busy_len(n);
            chkn("pwm_evt", k == 1 ? 32 : 0, n);
            wr(`EAW_A_ANGLE, 16'h0010);
            busy_len(n);
            chkn("angle_evt", k == 0 ? 32 : 0, n);
            wr(`EAW_A_TRI, 16'h0011);
            wr(`EAW_A_TRI, 16'h0022);
            busy_len(n);
            chkn("tri_early", 0, n);
            wr(`EAW_A_TRI, 16'h0030 + 16'(k));
            busy_len(n);
            chkn("tri_evt", k == 2 ? 32 : 0, n);
            if (k == 2) chk("tri_u", 16'h0011, {4'h0, duty.u});
            if (k == 2) chk("tri_v", 16'h0022, {4'h0, duty.v});
            if (k == 2) chk("tri_w", 16'h0032, {4'h0, duty.w});
        end
        wr(`EAW_A_PERIOD, 16'h0000);
        wr(`EAW_A_CTRLA, 16'h0001);
        wr(`EAW_A_ANGLE, 16'h017E);
        wirq(c);
        chk("angle_up", 16'h017F, {7'h00, angle_now});
        wirq(c);
        chkn("step_span", 16, c);
        chk("angle_wrap", 16'h0000, {7'h00, angle_now});
        wr(`EAW_A_CTRLA, 16'h0080);
        wr(`EAW_A_ANGLE, 16'h0001);
        wr(`EAW_A_CTRLA, 16'h0081);
        repeat (2) wirq(c);
        chk("angle_down", 16'h017F, {7'h00, angle_now});
        wr(`EAW_A_PERIOD, 16'h3000);
        repeat (2) wirq(c);
        s = 0;
        repeat (16) begin
            wirq(c);
            s += c;
        end
        chkn("corr_sum", 16 * 16 + 3, s);
        wr(`EAW_A_PERIOD, 16'h0010);
        for (int k = 0; k < 4; k++) begin
            wr(`EAW_A_CTRLA, 16'(8'h01 | (k << 4)));
            repeat (3) wirq(c);
            chkn("tick_sel", 16 << k, c);
        end
        wr(`EAW_A_CTRLA, 16'h0000);
        repeat (40) @(negedge clk_sys);
        chk("angle_stop", 16'h0000, {7'h00, angle_now});
        wr(`EAW_A_ANGLE, 16'h00AB);
        @(posedge clk_sys);
        pos_detect_evt <= 1'b1;
        @(posedge clk_sys);
        pos_detect_evt <= 1'b0;
        rdc("capture", `EAW_A_CAPT, 16'h00AB);
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(negedge clk_sys);
        chk("rst_duty_u", 16'h0000, {4'h0, duty.u});
        rdc("rst_angle", `EAW_A_ANGLE, 16'h0000);
        rdc("rst_capt", `EAW_A_CAPT, 16'h0000);
        conclude();
    end
endmodule
